// ### mt8_timer.sv
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mt8_sync (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      level_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // level changes only once the last two stages agree
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (s2 == s3) begin
            level_o <= s3;
        end
    end
endmodule

module mt8_timer (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    // register bus
    input  wire mt8_pkg::mt8_axi_req_t axi_i,
    output mt8_pkg::mt8_axi_rsp_t      axi_o,
    // count inputs
    input  wire logic                  ext_count_pin_i,
    input  wire logic                  fixed_freq_clock_i,
    // system modes
    input  wire logic                  stop_mode_i,
    input  wire logic                  stop_reset_i,
    input  wire logic                  bdm_active_i,
    // interrupt request
    output logic                       irq_o
);
    logic                     aw_full;
    logic                     w_full;
    logic [mt8_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0]               w_data;
    logic                     w_lane0;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic                     rd_sc;
    logic                     wr_fire;
    logic                     rd_acc;
    logic                     wr_sc;
    logic                     wr_cfg;
    logic                     wr_lim;
    logic                     wr_gate;
    logic                     wr_map;
    logic                     gate;
    logic                     overflow_flag;
    logic                     overflow_irq_enable;
    logic                     counter_halt;
    logic                     armed;
    mt8_pkg::mt8_src_t        source_select;
    logic [3:0]               prescale_select;
    logic [7:0]               count;
    logic [7:0]               limit;
    logic [7:0]               pre;
    logic [7:0]               mask;
    logic [7:0]               top;
    logic                     ext_count_input;
    logic                     ext_prev;
    logic                     ff_lvl;
    logic                     ff_prev;
    logic                     src_edge;
    logic                     run;
    logic                     tick;
    logic                     wrap;
    logic                     clr_req;
    logic                     tmr_rst;
    logic [7:0]               rd_byte;
    logic                     rd_map;

    // pin inputs into the bus clock domain
    mt8_sync u_ext_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (ext_count_pin_i),
        .level_o (ext_count_input)
    ); // (RL18)

    mt8_sync u_ff_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (fixed_freq_clock_i),
        .level_o (ff_lvl)
    );

    // bus handshakes
    assign axi_o.awready = ~aw_full & ~bvalid;
    assign axi_o.wready  = ~w_full & ~bvalid;
    assign axi_o.bvalid  = bvalid;
    assign axi_o.bresp   = bresp;
    assign axi_o.arready = ~rvalid;
    assign axi_o.rvalid  = rvalid;
    assign axi_o.rresp   = rresp;
    assign axi_o.rdata   = rdata;

    assign wr_fire = aw_full & w_full & ~bvalid;
    assign rd_acc  = axi_i.arvalid & ~rvalid;

    // write address and data taken in either order
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (axi_i.awvalid && !aw_full && !bvalid) begin
            aw_full <= 1'b1;
            aw_addr <= axi_i.awaddr;
        end else if (wr_fire) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            w_full  <= 1'b0;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (axi_i.wvalid && !w_full && !bvalid) begin
            w_full  <= 1'b1;
            w_data  <= axi_i.wdata[7:0];
            w_lane0 <= axi_i.wstrb[0];
        end else if (wr_fire) begin
            w_full <= 1'b0;
        end
    end

    // write decode; timer registers ignore writes while gated
    always_comb begin
        wr_map  = 1'b1;
        wr_sc   = 1'b0;
        wr_cfg  = 1'b0;
        wr_lim  = 1'b0;
        wr_gate = 1'b0;
        unique case (aw_addr)
            mt8_pkg::OFS_STATUS_CONTROL: wr_sc   = wr_fire & w_lane0 & gate;
            mt8_pkg::OFS_CLOCK_CONFIG:   wr_cfg  = wr_fire & w_lane0 & gate;
            mt8_pkg::OFS_COUNT_VALUE:    wr_map  = 1'b1; // (RL24)
            mt8_pkg::OFS_MODULO_LIMIT:   wr_lim  = wr_fire & w_lane0 & gate;
            mt8_pkg::OFS_PERIPH_GATE:    wr_gate = wr_fire & w_lane0;
            default:                     wr_map  = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid <= 1'b0;
            bresp  <= mt8_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_map ? mt8_pkg::RESP_OKAY : mt8_pkg::RESP_SLVERR;
        end else if (bvalid && axi_i.bready) begin
            bvalid <= 1'b0;
        end
    end

    // read mux; timer registers read zero while gated
    always_comb begin
        rd_byte = 8'h00;
        rd_map  = 1'b1;
        unique case (axi_i.araddr)
            mt8_pkg::OFS_STATUS_CONTROL: begin
                rd_byte = {overflow_flag, overflow_irq_enable, 1'b0, counter_halt, 4'h0}; // (RL7) (RL9)
            end
            mt8_pkg::OFS_CLOCK_CONFIG:   rd_byte = {2'h0, source_select, prescale_select};
            mt8_pkg::OFS_COUNT_VALUE:    rd_byte = count;
            mt8_pkg::OFS_MODULO_LIMIT:   rd_byte = limit;
            mt8_pkg::OFS_PERIPH_GATE:    rd_byte = {7'h00, gate};
            default:                     rd_map  = 1'b0;
        endcase
        if (!gate && axi_i.araddr != mt8_pkg::OFS_PERIPH_GATE) begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid <= 1'b0;
            rresp  <= mt8_pkg::RESP_OKAY;
            rdata  <= 32'h0000_0000;
            rd_sc  <= 1'b0;
        end else if (rd_acc) begin
            rvalid <= 1'b1;
            rresp  <= rd_map ? mt8_pkg::RESP_OKAY : mt8_pkg::RESP_SLVERR;
            rdata  <= {24'h00_0000, rd_byte};
            rd_sc  <= axi_i.araddr == mt8_pkg::OFS_STATUS_CONTROL;
        end else if (rvalid && axi_i.rready) begin
            rvalid <= 1'b0;
        end
    end

    // timer-level reset and counter clear requests
    assign tmr_rst = stop_reset_i; // (RL15)
    assign clr_req = (wr_sc & w_data[mt8_pkg::BIT_CLR]) | wr_lim; // (RL7) (RL24)

    // peripheral bus-clock gate
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gate <= 1'b0;
        end else if (tmr_rst) begin
            gate <= 1'b0; // (RL20)
        end else if (wr_gate) begin
            gate <= w_data[mt8_pkg::BIT_GATE]; // (RL20)
        end
    end

    // control fields
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_irq_enable <= 1'b0;
            counter_halt        <= mt8_pkg::RST_HALT;
        end else if (tmr_rst) begin
            overflow_irq_enable <= 1'b0; // (RL5)
            counter_halt        <= mt8_pkg::RST_HALT; // (RL8)
        end else if (wr_sc) begin
            overflow_irq_enable <= w_data[mt8_pkg::BIT_IE];
            counter_halt        <= w_data[mt8_pkg::BIT_HALT]; // (RL8)
        end
    end

    // a change of source or ratio leaves count and prescaler alone
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            source_select   <= mt8_pkg::SRC_BUS;
            prescale_select <= mt8_pkg::RST_PSEL;
        end else if (tmr_rst) begin
            source_select   <= mt8_pkg::SRC_BUS;
            prescale_select <= mt8_pkg::RST_PSEL;
        end else if (wr_cfg) begin
            source_select   <= mt8_pkg::mt8_src_t'(w_data[mt8_pkg::SRC_LSB +: 2]); // (RL21) (RL26)
            prescale_select <= w_data[mt8_pkg::PSEL_LSB +: 4];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            limit <= mt8_pkg::RST_LIMIT;
        end else if (tmr_rst) begin
            limit <= mt8_pkg::RST_LIMIT;
        end else if (wr_lim) begin
            limit <= w_data;
        end
    end

    // source edge detection
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ext_prev <= 1'b0;
            ff_prev  <= 1'b0;
        end else begin
            ext_prev <= ext_count_input;
            ff_prev  <= ff_lvl;
        end
    end

    always_comb begin
        unique case (source_select)
            mt8_pkg::SRC_BUS:      src_edge = 1'b1; // (RL10) (RL21)
            mt8_pkg::SRC_FIXED:    src_edge = ff_lvl & ~ff_prev; // (RL10)
            mt8_pkg::SRC_EXT_FALL: src_edge = ~ext_count_input & ext_prev; // (RL10)
            mt8_pkg::SRC_EXT_RISE: src_edge = ext_count_input & ~ext_prev; // (RL10)
        endcase
    end

    // wait mode is not a term here, so counting goes on through it
    assign run = gate & ~counter_halt & ~stop_mode_i & ~bdm_active_i; // (RL12) (RL14) (RL16) (RL17) (RL20)

    // prescaler: divide by two to the power of the select code, by 256 for codes of eight and up
    assign mask = (prescale_select >= mt8_pkg::PSEL_MAX) ? 8'hFF
                : 8'((9'h001 << prescale_select) - 9'h001); // (RL11) (RL22)
    assign tick = run & src_edge & ((pre & mask) == mask); // (RL11)

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre <= 8'h00;
        end else if (tmr_rst || clr_req) begin
            pre <= 8'h00;
        end else if (run && src_edge) begin
            pre <= pre + 8'h01;
        end
    end

    // counter
    assign top  = (limit == 8'h00) ? 8'hFF : limit; // (RL23)
    assign wrap = tick & (count == top); // (RL1) (RL25)

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count <= mt8_pkg::RST_COUNT;
        end else if (tmr_rst || clr_req) begin
            count <= mt8_pkg::RST_COUNT; // (RL7) (RL24)
        end else if (tick) begin
            count <= wrap ? 8'h00 : count + 8'h01; // (RL1) (RL25)
        end
    end

    // overflow flag; a wrap in the same cycle beats any clear except tmr_rst
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (tmr_rst) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1; // (RL2)
        end else if (clr_req) begin
            overflow_flag <= 1'b0; // (RL4)
        end else if (wr_sc && armed && !w_data[mt8_pkg::BIT_OVF]) begin
            overflow_flag <= 1'b0; // (RL3)
        end
    end

    // read of status while flag set arms the clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else if (tmr_rst || wr_sc) begin
            armed <= 1'b0;
        end else if (rd_acc && gate && axi_i.araddr == mt8_pkg::OFS_STATUS_CONTROL) begin
            armed <= overflow_flag; // (RL3)
        end
    end

    assign irq_o = overflow_flag & overflow_irq_enable; // (RL5)

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    halt_hold_a: assert property (counter_halt && !clr_req && !tmr_rst |=> $stable(count)) // (RL8)
        else $error("count moved while halted");
    flag_set_a: assert property (wrap && !tmr_rst |=> overflow_flag) // (RL2)
        else $error("wrap did not set overflow flag");
    wrap_zero_a: assert property (wrap && !clr_req && !tmr_rst |=> count == 8'h00) // (RL25)
        else $error("wrap did not return count to zero");
    free_run_a: assert property (tick && limit == 8'h00 && count == 8'hFE && !clr_req && !wr_lim
        && !tmr_rst |=> count == 8'hFF) // (RL23)
        else $error("zero limit did not run through full range");
    clr_bit_a: assert property (wr_sc && w_data[mt8_pkg::BIT_CLR] && !wrap && !tmr_rst
        |=> count == 8'h00 && !overflow_flag) // (RL7)
        else $error("clear bit did not reset count and flag");
    lim_write_a: assert property (wr_lim && !wrap && !tmr_rst |=> count == 8'h00 && !overflow_flag) // (RL24)
        else $error("limit write did not reset count and flag");
    no_arm_a: assert property (wr_sc && !armed && overflow_flag && !w_data[mt8_pkg::BIT_CLR]
        && !tmr_rst |=> overflow_flag) // (RL3)
        else $error("flag cleared without a prior status read");
    irq_hold_a: assert property (overflow_flag && overflow_irq_enable && !wr_sc && !clr_req
        && !tmr_rst |=> irq_o) // (RL5)
        else $error("interrupt dropped while flag and enable set");
    bdm_hold_a: assert property (bdm_active_i && !clr_req && !tmr_rst |=> $stable(count)) // (RL17)
        else $error("count moved during debug");
    stop_idle_a: assert property (stop_mode_i |-> !tick) // (RL14)
        else $error("tick during stop mode");
    gate_off_a: assert property (!gate && !tmr_rst |=> $stable(count) && $stable(overflow_flag)) // (RL20)
        else $error("gated timer changed state");
    div_two_a: assert property (tick && prescale_select == 4'h1 && !wr_cfg && !clr_req
        && !tmr_rst |=> !tick) // (RL11)
        else $error("divide by two ticked twice in a row");
    sc_zero_a: assert property (rvalid && rd_sc |-> rdata[5] == 1'b0 && rdata[3:0] == 4'h0) // (RL9)
        else $error("status unused bits not zero");
    cfg_keep_a: assert property (wr_cfg && !clr_req && !tick && !tmr_rst |=> $stable(count)) // (RL26)
        else $error("source change disturbed count");
    wr_resp_a: assert property (wr_fire |=> bvalid && !axi_o.awready && !axi_o.wready)
        else $error("write response not raised after write");

    mod_wrap_c: cover property (wrap && limit != 8'h00);
    irq_c: cover property ($rose(irq_o));
    ext_tick_c: cover property (tick && source_select == mt8_pkg::SRC_EXT_RISE);
    flag_clear_c: cover property (wr_sc && armed ##1 !overflow_flag);
endmodule

// ### mt8_pkg.sv
// How it works
// (RL1) eight-bit up-counter, free-running or modulo
// (RL2) overflow flag set on wrap to zero
// (RL3) flag clears after read-while-set then zero write
// (RL4) counter clear or limit write clears flag
// (RL5) interrupt when enable and flag both set
// (RL6) software clears flag before setting enable
// (RL7) clear bit zeroes count, reads zero
// (RL8) halt bit freezes count, reset sets it
// (RL9) status bits three to zero read zero
// (RL10) four count sources feed the prescaler
// (RL11) prescaler divides by powers two to 256
// (RL12) keeps counting while processor waits
// (RL13) software halts timer before idle waits
// (RL14) stopped in every stop mode
// (RL15) deep stop wake returns reset state
// (RL16) light stop interrupt exit keeps state
// (RL17) debug halts counting, resumes from held value
// (RL18) external pin synchronised to bus clock
// (RL19) external pin at most quarter bus rate
// (RL20) gate bit, cleared by reset, enables timer
// (RL21) source codes bus, fixed, falling, rising
// (RL22) prescale codes above eight divide by 256
// (RL23) zero limit runs full eight-bit range
// (RL24) count read-only, limit write zeroes count
// (RL25) each tick adds one, wraps at limit
// (RL26) source or ratio change keeps the count

package mt8_pkg;
    localparam int unsigned ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MODULO_LIMIT   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_GATE    = 8'h10;

    localparam int unsigned BIT_OVF   = 7;
    localparam int unsigned BIT_IE    = 6;
    localparam int unsigned BIT_CLR   = 5;
    localparam int unsigned BIT_HALT  = 4;
    localparam int unsigned BIT_GATE  = 0;
    localparam int unsigned SRC_LSB   = 4;
    localparam int unsigned PSEL_LSB  = 0;

    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [3:0] RST_PSEL  = 4'h0;
    localparam logic [3:0] PSEL_MAX  = 4'h8;
    localparam logic       RST_HALT  = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_BUS      = 2'h0,
        SRC_FIXED    = 2'h1,
        SRC_EXT_FALL = 2'h2,
        SRC_EXT_RISE = 2'h3
    } mt8_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } mt8_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } mt8_axi_rsp_t;
endpackage

// ### mt8_ext_src.sv
`timescale 1ns/1ps
module mt8_ext_src (
    // clock and control
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [8:0] pulses_i,
    // pin side
    output logic            busy_o,
    output logic            pin_o
);
    logic [8:0] left;
    logic [2:0] phase;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            left  <= 9'h000;
            phase <= 3'h0;
        end else if (go_i && left == 9'h000) begin
            left  <= pulses_i;
            phase <= 3'h0;
        end else if (left != 9'h000) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) begin
                left <= left - 9'h001;
            end
        end
    end

    // four cycles high, four low, idle low
    assign pin_o  = (left != 9'h000) && (phase < 3'h4);
    assign busy_o = (left != 9'h000) || go_i;
endmodule

// ### modulo_timer_8bit_tb.sv
`timescale 1ns/1ps
module modulo_timer_8bit_tb;
    localparam logic [7:0] SC = mt8_pkg::OFS_STATUS_CONTROL;
    localparam logic [7:0] CK = mt8_pkg::OFS_CLOCK_CONFIG;
    localparam logic [7:0] CN = mt8_pkg::OFS_COUNT_VALUE;
    localparam logic [7:0] ML = mt8_pkg::OFS_MODULO_LIMIT;
    localparam logic [7:0] GT = mt8_pkg::OFS_PERIPH_GATE;

    logic                  clock_i;
    logic                  rst_i;
    mt8_pkg::mt8_axi_req_t req;
    mt8_pkg::mt8_axi_rsp_t rsp;
    logic                  ext_pin;
    logic                  fixed_clk;
    logic                  stop_mode;
    logic                  stop_rst;
    logic                  bdm;
    logic                  go;
    logic                  busy;
    logic                  irq;
    logic [8:0]            npulse;
    logic [1:0]            last_resp;
    logic [31:0]           rv;
    int                    miscompares = 0;
    int                    compares = 0;
    int                    cycles = 0;

    mt8_timer dut (.clock_i(clock_i), .rst_i(rst_i), .axi_i(req), .axi_o(rsp), .ext_count_pin_i(ext_pin),
        .fixed_freq_clock_i(fixed_clk), .stop_mode_i(stop_mode), .stop_reset_i(stop_rst), .bdm_active_i(bdm),
        .irq_o(irq));
    mt8_ext_src src (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .pulses_i(npulse), .busy_o(busy),
        .pin_o(ext_pin));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    initial begin
        fixed_clk = 1'b0;
        #130;
        forever #400 fixed_clk = ~fixed_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // handshakes are sampled at the falling edge, where the response is settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_go;
        logic w_go;
        logic b_go;
        @(posedge clock_i);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= {24'h00_0000, d};
        req.wstrb   <= 4'hF;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(negedge clock_i);
            aw_go     = req.awvalid & rsp.awready;
            w_go      = req.wvalid & rsp.wready;
            b_go      = rsp.bvalid;
            last_resp = rsp.bresp;
            @(posedge clock_i);
            if (aw_go) req.awvalid <= 1'b0;
            if (w_go) req.wvalid <= 1'b0;
        end while (b_go !== 1'b1);
        req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_go;
        logic r_go;
        @(posedge clock_i);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(negedge clock_i);
            ar_go     = req.arvalid & rsp.arready;
            r_go      = rsp.rvalid;
            rv        = rsp.rdata;
            last_resp = rsp.rresp;
            @(posedge clock_i);
            if (ar_go) req.arvalid <= 1'b0;
        end while (r_go !== 1'b1);
        req.rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, {24'h00_0000, e});
    endtask

    // edges from the far side, then time for the pin synchroniser
    task automatic pulses(input logic [8:0] n);
        @(posedge clock_i);
        npulse <= n;
        go     <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        while (busy === 1'b1) @(posedge clock_i);
        repeat (8) @(posedge clock_i);
    endtask

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clock_i);
        chk(32'(irq), 32'h0000_0001);
    endtask

    initial begin
        rst_i     = 1'b1;
        req       = '0;
        stop_mode = 1'b0;
        stop_rst  = 1'b0;
        bdm       = 1'b0;
        go        = 1'b0;
        npulse    = 9'h000;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk(GT, 8'h00);
        rd_chk(SC, 8'h00);
        wr(GT, 8'h01);
        chk(32'(last_resp), 32'(mt8_pkg::RESP_OKAY));
        rd_chk(SC, 8'h10);
        rd_chk(CK, 8'h00);
        rd_chk(CN, 8'h00);
        rd_chk(ML, 8'h00);
        rd_chk(8'h20, 8'h00);
        chk(32'(last_resp), 32'(mt8_pkg::RESP_SLVERR));
        wr(8'h20, 8'h00);
        chk(32'(last_resp), 32'(mt8_pkg::RESP_SLVERR));
        wr(CK, 8'h30);
        wr(SC, 8'h00);
        pulses(9'd3);
        rd_chk(CN, 8'h03);
        wr(CN, 8'h55);
        rd_chk(CN, 8'h03);
        wr(CK, 8'h20);
        pulses(9'd2);
        rd_chk(CN, 8'h05);
        wr(ML, 8'h04);
        rd_chk(CN, 8'h00);
        pulses(9'd4);
        rd_chk(CN, 8'h04);
        pulses(9'd1);
        rd_chk(CN, 8'h00);
        wr(SC, 8'h00);
        rd_chk(SC, 8'h80);
        wr(SC, 8'h00);
        rd_chk(SC, 8'h00);
        wr(SC, 8'h40);
        chk(32'(irq), 32'h0000_0000);
        pulses(9'd5);
        chk(32'(irq), 32'h0000_0001);
        rd_chk(SC, 8'hC0);
        wr(SC, 8'h60);
        rd_chk(SC, 8'h40);
        chk(32'(irq), 32'h0000_0000);
        rd_chk(CN, 8'h00);
        pulses(9'd5);
        wr(ML, 8'h04);
        rd_chk(SC, 8'h40);
        wr(SC, 8'h00);
        pulses(9'd2);
        wr(SC, 8'h10);
        pulses(9'd3);
        rd_chk(CN, 8'h02);
        wr(SC, 8'h00);
        pulses(9'd1);
        rd_chk(CN, 8'h03);
        stop_mode <= 1'b1;
        pulses(9'd2);
        stop_mode <= 1'b0;
        rd_chk(CN, 8'h03);
        bdm <= 1'b1;
        pulses(9'd2);
        bdm <= 1'b0;
        pulses(9'd1);
        rd_chk(CN, 8'h04);
        wr(ML, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(CK, 8'h30 | 8'(k));
            wr(SC, 8'h20);
            pulses(9'(2 << k));
            rd_chk(CN, 8'h02);
        end
        wr(CK, 8'h39);
        wr(SC, 8'h20);
        pulses(9'd255);
        rd_chk(CN, 8'h00);
        pulses(9'd1);
        rd_chk(CN, 8'h01);
        wr(CK, 8'h30);
        wr(SC, 8'h20);
        pulses(9'd255);
        rd_chk(CN, 8'hFF);
        rd_chk(SC, 8'h00);
        pulses(9'd1);
        rd_chk(SC, 8'h80);
        wr(SC, 8'h10);
        wr(ML, 8'h08);
        wr(CK, 8'h00);
        chk(32'(irq), 32'h0000_0000);
        wr(SC, 8'h40);
        wait_irq(40);
        wr(SC, 8'h10);
        wr(ML, 8'h02);
        wr(CK, 8'h10);
        wr(SC, 8'h40);
        wait_irq(200);
        stop_rst <= 1'b1;
        @(posedge clock_i);
        stop_rst <= 1'b0;
        @(posedge clock_i);
        chk(32'(irq), 32'h0000_0000);
        rd_chk(GT, 8'h00);
        wr(GT, 8'h01);
        rd_chk(SC, 8'h10);
        rd_chk(ML, 8'h00);
        rd_chk(CK, 8'h00);
        report_and_stop();
    end
endmodule
